// ---- design/dram_ctl_pkg.sv ----
// Shared constants and carrier types for the parity DRAM board controller.
package dram_ctl_pkg;
	localparam int CLK_NS = 40;
	localparam int REFRESH_INTERVAL_NS = 16000;
	localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS / CLK_NS;
	localparam int REFRESH_MAX_NS = 550;
	localparam int REFRESH_CYC = REFRESH_MAX_NS / CLK_NS;
	localparam int CYCLE_MAX_NS = 500;
	localparam int CYCLE_MAX_CYC = CYCLE_MAX_NS / CLK_NS;
	localparam int ACCESS_NS = 320;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int WINDOW_BLOCKS = 32;
	localparam int BLOCK_LSB = 14;
	localparam int ADDR_W = 24;
	localparam int OFFS_W = 19;
	localparam int BASE_W = 10;
	localparam int BANK_LSB = 17;
	localparam int ROW_LSB = 9;
	localparam int COL_LSB = 1;
	localparam logic [7:0] IO_LOW_RANGE = 8'h00;
	localparam logic [7:0] IO_HIGH_RANGE = 8'h40;
	localparam logic [9:0] FLAG_RESET = 10'h000;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [15:0] wdata;
		logic [1:0] byte_en;
	} host_req_t;

	typedef struct packed {
		logic [1:0] bank;
		logic [7:0] row;
		logic [7:0] col;
		logic [17:0] wdata;
		logic [1:0] lane_en;
		logic select;
		logic write;
		logic refresh;
	} ram_ctl_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_REFRESH = 4'b0010,
		ST_ACCESS = 4'b0100,
		ST_ACK = 4'b1000
	} ctl_state_t;
endpackage

// ---- design/parity_dram_board_controller.sv ----
// Refresh, window decode, byte parity and error flag control for a DRAM board.
// Overview of operation
// - A new refresh operation starts every 16 microseconds.
// - Refresh holds the array at most 550 ns; colliding host accesses wait.
// - Each written byte gets its own parity bit stored beside it.
// - Each read recomputes byte parity and compares it with the stored bits of its enabled byte lanes.
// - A read parity mismatch can raise an interrupt toward the host.
// - A parity error captures the failing row and bank into the flag register.
// - The flag register answers host I/O reads; the host reads the failing location.
// - An indicator output lights once a parity error has been detected.
// - A 512K-byte read/write window is decoded in host memory space.
// - The window base is a static input on any 16K boundary in 16 MB.
// - The flag register I/O address lies in 00H-0FH or 40H-4FH by static input.
// - While the active-low protect input is low, array accesses are refused.
// - A host read or write cycle to the array that meets no refresh completes within 500 ns.
`timescale 1ns/100ps
`default_nettype none
module parity_dram_board_controller (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire dram_ctl_pkg::host_req_t req_i,
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [9:0] base_sel_i,
	input wire logic io_range_sel_i,
	input wire logic [3:0] io_port_sel_i,
	input wire logic protect_n_i,
	input wire logic irq_enable_i,
	input wire logic [17:0] ram_rdata_i,
	output logic ack_o,
	output logic [15:0] rdata_o,
	output logic rdata_oe_o,
	output logic irq_o,
	output logic led_o,
	output dram_ctl_pkg::ram_ctl_t ram_o
);
	function automatic logic odd_par(input logic [7:0] b);
		odd_par = ~(^b);
	endfunction

	dram_ctl_pkg::ctl_state_t state_reg;
	logic [8:0] ref_timer_reg;
	logic ref_pend_reg;
	logic [3:0] cnt_reg;
	logic served_reg;
	logic err_reg;
	logic [9:0] flag_reg;
	logic ack_reg;
	logic [15:0] rdata_reg;
	logic rdata_oe_reg;
	logic irq_reg;
	dram_ctl_pkg::ram_ctl_t ram_reg;
	logic [1:0] lat_be_reg;
	logic lat_write_reg;

	logic [dram_ctl_pkg::BASE_W-1:0] blk;
	logic [dram_ctl_pkg::BASE_W-1:0] blk_off;
	logic mem_hit;
	logic io_hit;
	logic [dram_ctl_pkg::OFFS_W-1:0] offs;
	logic mem_req;
	logic io_req;
	logic [1:0] lane_bad;
	logic par_err;
	logic ref_tick;

	assign blk = req_i.addr[dram_ctl_pkg::ADDR_W-1:dram_ctl_pkg::BLOCK_LSB];
	assign blk_off = blk - base_sel_i;
	// The window is contiguous from the base; the base is trusted not to cross 16 MB.
	assign mem_hit = (blk >= base_sel_i) && (blk_off < 10'(dram_ctl_pkg::WINDOW_BLOCKS));
	assign offs = {blk_off[4:0], req_i.addr[dram_ctl_pkg::BLOCK_LSB-1:0]};
	assign io_hit = req_i.addr[7:0] == ((io_range_sel_i ? dram_ctl_pkg::IO_HIGH_RANGE
		: dram_ctl_pkg::IO_LOW_RANGE) | {4'h0, io_port_sel_i});
	// Protect gates only array traffic, so the flag port stays readable.
	assign mem_req = (mem_rd_i || mem_wr_i) && mem_hit && protect_n_i && !served_reg;
	assign io_req = (io_rd_i || io_wr_i) && io_hit && !served_reg;
	assign ref_tick = ref_timer_reg == 9'(dram_ctl_pkg::REFRESH_INTERVAL_CYC - 1);
	assign lane_bad[0] = lat_be_reg[0] && (odd_par(ram_rdata_i[7:0]) != ram_rdata_i[16]);
	assign lane_bad[1] = lat_be_reg[1] && (odd_par(ram_rdata_i[15:8]) != ram_rdata_i[17]);
	assign par_err = (state_reg == dram_ctl_pkg::ST_ACCESS) && (cnt_reg == 4'h0)
		&& !lat_write_reg && (lane_bad != 2'b00);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ref_timer_reg <= 9'h000;
		end else if (ref_tick) begin
			ref_timer_reg <= 9'h000;
		end else begin
			ref_timer_reg <= ref_timer_reg + 9'h001;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ref_pend_reg <= 1'b0;
		end else if (ref_tick) begin
			ref_pend_reg <= 1'b1;
		end else if (state_reg == dram_ctl_pkg::ST_IDLE) begin
			ref_pend_reg <= 1'b0;
		end
	end

	// Refresh wins a tie with a host request; the host simply sees a later acknowledge.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= dram_ctl_pkg::ST_IDLE;
			cnt_reg <= 4'h0;
		end else begin
			case (state_reg)
				dram_ctl_pkg::ST_IDLE: begin
					if (ref_pend_reg) begin
						state_reg <= dram_ctl_pkg::ST_REFRESH;
						cnt_reg <= 4'(dram_ctl_pkg::REFRESH_CYC - 1);
					end else if (mem_req) begin
						state_reg <= dram_ctl_pkg::ST_ACCESS;
						cnt_reg <= 4'(dram_ctl_pkg::ACCESS_CYC - 1);
					end else if (io_req) begin
						state_reg <= dram_ctl_pkg::ST_ACK;
					end
				end
				dram_ctl_pkg::ST_REFRESH: begin
					if (cnt_reg == 4'h0) begin
						state_reg <= dram_ctl_pkg::ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				dram_ctl_pkg::ST_ACCESS: begin
					if (cnt_reg == 4'h0) begin
						state_reg <= dram_ctl_pkg::ST_ACK;
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				default: begin
					state_reg <= dram_ctl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ram_reg <= '0;
			lat_be_reg <= 2'b00;
			lat_write_reg <= 1'b0;
		end else if (state_reg == dram_ctl_pkg::ST_IDLE && ref_pend_reg) begin
			ram_reg <= '0;
			ram_reg.refresh <= 1'b1;
		end else if (state_reg == dram_ctl_pkg::ST_IDLE && mem_req) begin
			ram_reg.bank <= offs[18:dram_ctl_pkg::BANK_LSB];
			ram_reg.row <= offs[16:dram_ctl_pkg::ROW_LSB];
			ram_reg.col <= offs[8:dram_ctl_pkg::COL_LSB];
			ram_reg.wdata <= {odd_par(req_i.wdata[15:8]), odd_par(req_i.wdata[7:0]),
				req_i.wdata};
			ram_reg.lane_en <= req_i.byte_en;
			ram_reg.select <= 1'b1;
			ram_reg.write <= mem_wr_i;
			ram_reg.refresh <= 1'b0;
			lat_be_reg <= req_i.byte_en;
			lat_write_reg <= mem_wr_i;
		end else if (cnt_reg == 4'h0) begin
			ram_reg.select <= 1'b0;
			ram_reg.write <= 1'b0;
			ram_reg.refresh <= 1'b0;
		end
	end

	// A strobe is served once; the host must drop it before the next request.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			served_reg <= 1'b0;
		end else if (state_reg == dram_ctl_pkg::ST_ACK) begin
			served_reg <= 1'b1;
		end else if (!(mem_rd_i || mem_wr_i || io_rd_i || io_wr_i)) begin
			served_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdata_reg <= dram_ctl_pkg::DATA_RESET;
			rdata_oe_reg <= 1'b0;
		end else begin
			ack_reg <= (state_reg == dram_ctl_pkg::ST_ACCESS && cnt_reg == 4'h0)
				|| (state_reg == dram_ctl_pkg::ST_IDLE && !ref_pend_reg && !mem_req && io_req);
			rdata_oe_reg <= 1'b0;
			if (state_reg == dram_ctl_pkg::ST_ACCESS && cnt_reg == 4'h0 && !lat_write_reg) begin
				rdata_reg <= ram_rdata_i[15:0];
				rdata_oe_reg <= 1'b1;
			end else if (state_reg == dram_ctl_pkg::ST_IDLE && !ref_pend_reg && !mem_req
				&& io_req && io_rd_i) begin
				rdata_reg <= {5'h00, err_reg, flag_reg};
				rdata_oe_reg <= 1'b1;
			end
		end
	end

	// An I/O write clears the error; a new error in that same cycle still sets it.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			err_reg <= 1'b0;
			flag_reg <= dram_ctl_pkg::FLAG_RESET;
		end else if (par_err) begin
			err_reg <= 1'b1;
			flag_reg <= {ram_reg.bank, ram_reg.row};
		end else if (state_reg == dram_ctl_pkg::ST_IDLE && !ref_pend_reg && !mem_req
			&& io_req && io_wr_i) begin
			err_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_enable_i && (err_reg || par_err);
		end
	end

	assign ack_o = ack_reg;
	assign rdata_o = rdata_reg;
	assign rdata_oe_o = rdata_oe_reg;
	assign irq_o = irq_reg;
	assign led_o = err_reg;
	assign ram_o = ram_reg;

	// Helper count of refresh cycles, read only by the refresh length checks.
	logic [3:0] ref_run_reg;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ref_run_reg <= 4'h0;
		end else if (ram_reg.refresh) begin
			ref_run_reg <= ref_run_reg + 4'h1;
		end else begin
			ref_run_reg <= 4'h0;
		end
	end

	refresh_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ref_tick |-> ##[1:14] (state_reg == dram_ctl_pkg::ST_REFRESH))
		else $error("refresh not started after interval");
	refresh_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(ram_o.refresh) |-> ref_run_reg == 4'(dram_ctl_pkg::REFRESH_CYC))
		else $error("refresh length wrong");
	refresh_max_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ram_o.refresh |-> ref_run_reg < 4'(dram_ctl_pkg::REFRESH_CYC))
		else $error("refresh held too long");
	write_parity_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ram_o.write |-> ram_o.wdata[16] == ~(^ram_o.wdata[7:0])
		&& ram_o.wdata[17] == ~(^ram_o.wdata[15:8]))
		else $error("write parity wrong");
	flag_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
		par_err |=> led_o && flag_reg == $past({ram_o.bank, ram_o.row}))
		else $error("flag not captured");
	parity_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(par_err && irq_enable_i) |=> irq_o)
		else $error("interrupt missing");
	protect_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!protect_n_i && state_reg == dram_ctl_pkg::ST_IDLE |=> state_reg != dram_ctl_pkg::ST_ACCESS)
		else $error("access while protected");
	cycle_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ram_o.select) |-> ##[1:11] ack_o)
		else $error("array cycle too long");
	io_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == dram_ctl_pkg::ST_ACK && !$past(ram_o.select)) |-> ack_o)
		else $error("io port not answered");
	window_hit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ram_o.select) |-> $past(mem_hit))
		else $error("access outside window");

	refresh_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(ram_o.refresh));
	parity_err_c: cover property (@(posedge clk_i) disable iff (rst_i) par_err);
	collision_c: cover property (@(posedge clk_i) disable iff (rst_i)
		state_reg == dram_ctl_pkg::ST_REFRESH && (mem_rd_i || mem_wr_i) && mem_hit);
	io_read_c: cover property (@(posedge clk_i) disable iff (rst_i)
		state_reg == dram_ctl_pkg::ST_IDLE && io_req && io_rd_i);
endmodule // parity_dram_board_controller
`default_nettype wire

// ---- bench/ram_array_model.sv ----
// Behavioural DRAM array that stores data and parity bits per byte lane.
`timescale 1ns/100ps
`default_nettype none
module ram_array_model (
	input wire logic clk_i,
	input wire dram_ctl_pkg::ram_ctl_t ram_i,
	input wire logic flip_i,
	output logic [17:0] rdata_o
);
	logic [17:0] mem [int];
	logic [17:0] w;
	int a;
	initial rdata_o = 18'h2_AAAA;
	always @(posedge clk_i) begin
		a = int'({ram_i.bank, ram_i.row, ram_i.col});
		w = mem.exists(a) ? mem[a] : 18'h0_0000;
		if (ram_i.select && ram_i.write) begin
			if (ram_i.lane_en[0]) begin
				w[7:0] = ram_i.wdata[7:0];
				w[16] = ram_i.wdata[16];
			end
			if (ram_i.lane_en[1]) begin
				w[15:8] = ram_i.wdata[15:8];
				w[17] = ram_i.wdata[17];
			end
			mem[a] = w;
		end
		// Outside a read the lines float, so they never repeat the last data.
		rdata_o <= (ram_i.select && !ram_i.write) ? w ^ {1'b0, flip_i, 16'h0000} : ~rdata_o;
	end
endmodule // ram_array_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the parity DRAM board controller.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam logic [3:0] MR = 4'b1000;
	localparam logic [3:0] MW = 4'b0100;
	localparam logic [3:0] IR = 4'b0010;
	localparam logic [3:0] IW = 4'b0001;
	localparam logic [23:0] B = 24'h10_4000;
	logic clk, rst, prot_n, irq_en, rng, flip, ack, oe, irq, led, ok;
	logic [3:0] strb, port;
	logic [9:0] base;
	logic [15:0] rdata, got;
	logic [17:0] rram, lastw;
	dram_ctl_pkg::host_req_t req;
	dram_ctl_pkg::ram_ctl_t ram;
	int err_count, comparisons, cyc, rcnt, rlen, nref, nwait;
	// The window at 104000H ends well below a 4 MB boundary.
	parity_dram_board_controller i_dut (
		.clk_i(clk), .rst_i(rst), .req_i(req), .mem_rd_i(strb[3]), .mem_wr_i(strb[2]),
		.io_rd_i(strb[1]), .io_wr_i(strb[0]), .base_sel_i(base), .io_range_sel_i(rng),
		.io_port_sel_i(port), .protect_n_i(prot_n), .irq_enable_i(irq_en), .ram_rdata_i(rram),
		.ack_o(ack), .rdata_o(rdata), .rdata_oe_o(oe), .irq_o(irq), .led_o(led), .ram_o(ram));
	ram_array_model i_ram (.clk_i(clk), .ram_i(ram), .flip_i(flip), .rdata_o(rram));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		#1;
		cyc++;
		rcnt++;
		if (ram.select === 1'b1 && ram.write === 1'b1) lastw = ram.wdata;
		if (ram.refresh === 1'b1) begin
			if (rlen == 0) begin
				if (nref > 0) check(rcnt, dram_ctl_pkg::REFRESH_INTERVAL_CYC);
				nref++;
				rcnt = 0;
			end
			rlen++;
		end else if (rlen > 0) begin
			check(rlen, dram_ctl_pkg::REFRESH_CYC);
			rlen = 0;
		end
		if (cyc == 3000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic acc(input logic [3:0] k, input logic [23:0] ad, input logic [15:0] wd,
		input logic [1:0] be);
		int n;
		req = '{addr: ad, wdata: wd, byte_en: be};
		strb = k;
		ok = 1'b0;
		n = 0;
		while (ok !== 1'b1 && n < 30) begin
			@(posedge clk);
			#1;
			n++;
			ok = ack;
			got = rdata;
		end
		if (ok === 1'b1) check(oe, k[3] | k[1]);
		nwait = n;
		strb = 4'b0000;
		// A refresh collision may add its own length to the cycle.
		if (ok === 1'b1) check(n <= dram_ctl_pkg::CYCLE_MAX_CYC + dram_ctl_pkg::REFRESH_CYC, 1);
		// The served mark is set in the answer cycle, so the strobe stays low two edges.
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic t_rw;
		acc(MW, B + 24'h00_0010, 16'h1234, 2'b11);
		check(lastw, {~^8'h12, ~^8'h34, 16'h1234});
		acc(MW, B + 24'h00_0010, 16'hA500, 2'b10);
		check({lastw[17], lastw[15:8]}, {~^8'hA5, 8'hA5});
		acc(MR, B + 24'h00_0010, 16'h0000, 2'b11);
		check({got, led}, {16'hA534, 1'b0});
	endtask
	task automatic t_window;
		acc(MW, B + 24'h07_FFFE, 16'h0F0F, 2'b11);
		acc(MR, B + 24'h07_FFFE, 16'h0000, 2'b11);
		check({ok, got}, {1'b1, 16'h0F0F});
		acc(MR, B + 24'h08_0000, 16'h0000, 2'b11);
		check(ok, 0);
		acc(MR, B - 24'h00_0002, 16'h0000, 2'b11);
		check(ok, 0);
		base = 10'h3E0;
		acc(MW, 24'hF8_0020, 16'h5AA5, 2'b11);
		acc(MR, 24'hF8_0020, 16'h0000, 2'b11);
		check({ok, got}, {1'b1, 16'h5AA5});
		acc(MR, B + 24'h00_0010, 16'h0000, 2'b11);
		check(ok, 0);
		base = 10'h041;
	endtask
	task automatic t_protect;
		prot_n = 1'b0;
		acc(MW, B + 24'h00_0010, 16'hFFFF, 2'b11);
		check(ok, 0);
		prot_n = 1'b1;
		acc(MR, B + 24'h00_0010, 16'h0000, 2'b11);
		check(got, 16'hA534);
	endtask
	task automatic t_parity;
		logic [18:0] off;
		off = 19'h5_A202;
		acc(MW, B + {5'h00, off}, 16'h00FF, 2'b11);
		flip = 1'b1;
		acc(MR, B + {5'h00, off}, 16'h0000, 2'b11);
		flip = 1'b0;
		check({led, irq}, 2'b10);
		irq_en = 1'b1;
		@(posedge clk);
		#1;
		check(irq, 1);
		acc(IR, 24'h00_0047, 16'h0000, 2'b11);
		check(ok, 0);
		rng = 1'b1;
		acc(IR, 24'h00_0047, 16'h0000, 2'b11);
		check(got, {5'h00, 1'b1, off[18:17], off[16:9]});
		acc(IW, 24'h00_0047, 16'h0000, 2'b11);
		check({led, irq}, 2'b00);
		rng = 1'b0;
		acc(IR, 24'h00_0007, 16'h0000, 2'b11);
		check({ok, got[10]}, 2'b10);
		flip = 1'b1;
		acc(MR, B + {5'h00, off}, 16'h0000, 2'b11);
		flip = 1'b0;
		check({led, irq}, 2'b11);
		port = 4'hC;
		acc(IR, 24'h00_000C, 16'h0000, 2'b11);
		check({ok, got}, {1'b1, 5'h00, 1'b1, off[18:17], off[16:9]});
		acc(IW, 24'h00_000C, 16'h0000, 2'b11);
		check({ok, led}, 2'b10);
		port = 4'h7;
	endtask
	task automatic t_collide;
		while (ram.refresh !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		acc(MW, B + 24'h00_0040, 16'hC33C, 2'b01);
		check(nwait >= dram_ctl_pkg::REFRESH_CYC, 1);
		acc(MR, B + 24'h00_0040, 16'h0000, 2'b01);
		check({ok, got[7:0], led}, {1'b1, 8'h3C, 1'b0});
	endtask
	initial begin
		rst = 1'b1;
		strb = 4'b0000;
		req = '0;
		prot_n = 1'b1;
		irq_en = 1'b0;
		rng = 1'b0;
		flip = 1'b0;
		base = 10'h041;
		port = 4'h7;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		check({ack, oe, irq, led}, 4'h0);
		t_rw();
		t_window();
		t_protect();
		t_parity();
		t_collide();
		repeat (900) @(posedge clk);
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
